// ---- core/msp_encoder.sv ----
// Purpose: drives transmit, receive and queue status codes from mac core state
// Assumes: core inputs are on clk; registers reached over a plain strobe port
// Notes:   read data valid the cycle after the read strobe
//
// Functional notes
// - transmit status uses the listed eleven four-bit codes
// - transmit codes 3, 7, 8, E and F are never driven
// - extended transmit codes only when tx_status_ext_enable set, else legacy
// - extended receive codes only when rx_status_ext_enable set; top bit 0 is legacy
// - starting delimiter plus non-data symbol drives 10x001
// - top bit set: 100010 strip in special mode, 100101 abort, 100110 flush
// - other receive codes with top bit set are never driven
// - queue code 000 means idle or space remains while loading
// - queue codes 001, 010, 011 name the unloading queue; 100 never driven
// - queue codes 101 underrun, 110 full, 111 almost full
// - almost full shown on the first host write of an almost-full run, every write only with repeat
// - only synchronous, async 0 and async 1 queues exist
// - timer_carry_split bit has no effect; timers count whole
// - no single-frame receive, only tagged multi-queue operation
// - non-quiescent transmit code lasts one cycle; none for repeated frames
// - repeated almost full only with almost_full_repeat_enable, else one write
`timescale 1ns/100ps
module msp_encoder
   import msp_pkg::*;
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // register port
   input  wire logic [7:0]   reg_addr,
   input  wire logic [31:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic      [31:0]  reg_rdata,
   // mac core state
   input  wire msp_tx_evt_t  tx_evt,
   input  wire msp_rx_evt_t  rx_evt,
   input  wire msp_q_state_t q_state,
   // status pins and interrupt
   output msp_pins_t         pins,
   output logic              irq
);

   logic [2:0]  mode3_q;
   logic [15:0] mode1_q;
   logic [4:0]  status_q;
   logic [4:0]  mask_q;
   logic [4:0]  events;
   logic        rd_status;
   logic        queue_almost_full_done_q;
   logic        queue_almost_full_done_d;
   logic [3:0]  tx_d;
   logic [5:0]  rx_d;
   logic [2:0]  qc_d;
   logic        tx_ext;
   logic        rx_ext;
   logic        af_rep;

   assign tx_ext = mode3_q[MSP_BIT_TX_EXT];
   assign rx_ext = mode3_q[MSP_BIT_RX_EXT];
   assign af_rep = mode3_q[MSP_BIT_AF_REP];

   // mode registers; timer_carry_split is stored only, timers ignore it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode3_q <= MSP_MODE3_RST;
         mode1_q <= MSP_MODE1_RST;
      end else if (reg_wr) begin
         if (reg_addr == MSP_OFS_MODE3) begin
            mode3_q <= reg_wdata[2:0];
         end
         if (reg_addr == MSP_OFS_MODE1) begin
            mode1_q <= reg_wdata[15:0];
         end
      end
   end

   // interrupt mask
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= MSP_MASK_RST;
      end else if (reg_wr && reg_addr == MSP_OFS_MASK) begin
         mask_q <= reg_wdata[4:0];
      end
   end

   // transmit status: one cycle per event, repeated frames silent
   always_comb begin
      tx_d = MSP_XS_QUIET;
      if (tx_evt.valid && !tx_evt.repeated) begin
         case (tx_evt.kind)
            MSP_TX_ABORT:    tx_d = MSP_XS_TX_ABORT;
            MSP_TX_TOKEN:    tx_d = MSP_XS_TOKEN;
            MSP_TX_SYNC:     tx_d = MSP_XS_SYNC;
            MSP_TX_ASYNC0:   tx_d = MSP_XS_ASYNC0;
            MSP_TX_ASYNC1:   tx_d = MSP_XS_ASYNC1;
            MSP_TX_CLAIM:    tx_d = MSP_XS_CLAIM;
            MSP_TX_BEACON:   tx_d = MSP_XS_BEACON;
            MSP_TX_VOID:     tx_d = MSP_XS_VOID;
            MSP_TX_MAC_ABT:  tx_d = MSP_XS_MAC_ABT;
            MSP_TX_VOID_ABT: tx_d = MSP_XS_VOID_ABT;
            default:         tx_d = MSP_XS_QUIET;
         endcase
         // legacy pins lack the top bit: such events stay quiescent
         if (!tx_ext && tx_d[3]) begin
            tx_d = MSP_XS_QUIET;
         end
      end
   end

   // receive status: extended codes only when enabled
   always_comb begin
      rx_d = {1'b0, rx_evt.legacy};
      if (rx_ext) begin
         case (rx_evt.kind)
            MSP_RX_SD_NDATA: rx_d = MSP_RS_SD_NONDATA;
            MSP_RX_STRIP: begin
               if (rx_evt.online_special_mode) begin
                  rx_d = MSP_RS_OSM_STRIP;
               end
            end
            MSP_RX_ABORT:    rx_d = MSP_RS_ABORT;
            MSP_RX_FLUSH:    rx_d = MSP_RS_FLUSH;
            default:         rx_d = {1'b0, rx_evt.legacy};
         endcase
      end
   end

   // queue control: underrun, full, almost full, unload, then idle
   always_comb begin
      qc_d         = MSP_QC_IDLE;
      queue_almost_full_done_d = queue_almost_full_done_q;
      if (!q_state.queue_almost_full || q_state.full) begin
         queue_almost_full_done_d = 1'b0;
      end
      if (q_state.underrun) begin
         qc_d = MSP_QC_UNDERRUN;
      end else if (q_state.full) begin
         qc_d = MSP_QC_FULL;
      end else if (q_state.queue_almost_full && q_state.host_write_req
                   && (af_rep || !queue_almost_full_done_q)) begin
         qc_d         = MSP_QC_QUEUE_ALMOST_FULL;
         queue_almost_full_done_d = 1'b1;
      end else begin
         case (q_state.unload)
            MSP_Q_SYNC:   qc_d = MSP_QC_SYNC;
            MSP_Q_ASYNC0: qc_d = MSP_QC_ASYNC0;
            MSP_Q_ASYNC1: qc_d = MSP_QC_ASYNC1;
            default:      qc_d = MSP_QC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         queue_almost_full_done_q <= 1'b0;
      end else begin
         queue_almost_full_done_q <= queue_almost_full_done_d;
      end
   end

   // status pins from flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pins.tx_status_code     <= MSP_XS_QUIET;
         pins.rx_status_code     <= 6'h00;
         pins.queue_control_code <= MSP_QC_IDLE;
      end else begin
         pins.tx_status_code     <= tx_d;
         pins.rx_status_code     <= rx_d;
         pins.queue_control_code <= qc_d;
      end
   end

   // sticky events; a set in the clearing cycle wins
   always_comb begin
      events                  = 5'h00;
      events[MSP_ST_TX_ABORT] = (tx_d == MSP_XS_TX_ABORT) || (tx_d == MSP_XS_MAC_ABT)
                                || (tx_d == MSP_XS_VOID_ABT);
      events[MSP_ST_RX_ABORT] = (rx_d == MSP_RS_ABORT);
      events[MSP_ST_RX_FLUSH] = (rx_d == MSP_RS_FLUSH);
      events[MSP_ST_UNDERRUN] = q_state.underrun;
      events[MSP_ST_Q_FULL]   = q_state.full;
   end

   assign rd_status = reg_rd && (reg_addr == MSP_OFS_STATUS);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= 5'h00;
      end else if (rd_status) begin
         status_q <= events;
      end else begin
         status_q <= status_q | events;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & mask_q & ~({5{rd_status}})) || |(events & mask_q);
      end
   end

   // read data, one cycle after the strobe, zero elsewhere
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            MSP_OFS_MODE3:  reg_rdata <= {29'h0, mode3_q};
            MSP_OFS_MODE1:  reg_rdata <= {16'h0, mode1_q};
            MSP_OFS_STATUS: reg_rdata <= {27'h0, status_q};
            MSP_OFS_MASK:   reg_rdata <= {27'h0, mask_q};
            MSP_OFS_PINS:   reg_rdata <= {19'h0, pins};
            default:        reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule

// ---- core/msp_pkg.sv ----
// Purpose: shared constants and types of the mac status pin encoder
// Assumes: one 200 MHz clock, plain register port with 8-bit address
// Notes:   all codes and offsets are named here once
package msp_pkg;
   // register offsets
   localparam logic [7:0] MSP_OFS_MODE3  = 8'h00;
   localparam logic [7:0] MSP_OFS_MODE1  = 8'h04;
   localparam logic [7:0] MSP_OFS_STATUS = 8'h08;
   localparam logic [7:0] MSP_OFS_MASK   = 8'h0C;
   localparam logic [7:0] MSP_OFS_PINS   = 8'h10;
   // mode_register_three fields
   localparam int MSP_BIT_TX_EXT  = 0;
   localparam int MSP_BIT_RX_EXT  = 1;
   localparam int MSP_BIT_AF_REP  = 2;
   // mode_register_one fields
   localparam int MSP_BIT_CARRY   = 6;
   // reset values
   localparam logic [2:0]  MSP_MODE3_RST = 3'h0;
   localparam logic [15:0] MSP_MODE1_RST = 16'h0000;
   localparam logic [4:0]  MSP_MASK_RST  = 5'h00;
   // status bit positions
   localparam int MSP_ST_TX_ABORT = 0;
   localparam int MSP_ST_RX_ABORT = 1;
   localparam int MSP_ST_RX_FLUSH = 2;
   localparam int MSP_ST_UNDERRUN = 3;
   localparam int MSP_ST_Q_FULL   = 4;
   // transmit status codes
   localparam logic [3:0] MSP_XS_QUIET    = 4'h0;
   localparam logic [3:0] MSP_XS_TX_ABORT = 4'h1;
   localparam logic [3:0] MSP_XS_TOKEN    = 4'h2;
   localparam logic [3:0] MSP_XS_SYNC     = 4'h4;
   localparam logic [3:0] MSP_XS_ASYNC0   = 4'h5;
   localparam logic [3:0] MSP_XS_ASYNC1   = 4'h6;
   localparam logic [3:0] MSP_XS_CLAIM    = 4'h9;
   localparam logic [3:0] MSP_XS_BEACON   = 4'hA;
   localparam logic [3:0] MSP_XS_VOID     = 4'hB;
   localparam logic [3:0] MSP_XS_MAC_ABT  = 4'hC;
   localparam logic [3:0] MSP_XS_VOID_ABT = 4'hD;
   // extended receive status codes
   localparam logic [5:0] MSP_RS_SD_NONDATA = 6'h21;
   localparam logic [5:0] MSP_RS_OSM_STRIP  = 6'h22;
   localparam logic [5:0] MSP_RS_ABORT      = 6'h25;
   localparam logic [5:0] MSP_RS_FLUSH      = 6'h26;
   // queue control codes
   localparam logic [2:0] MSP_QC_IDLE     = 3'h0;
   localparam logic [2:0] MSP_QC_SYNC     = 3'h1;
   localparam logic [2:0] MSP_QC_ASYNC0   = 3'h2;
   localparam logic [2:0] MSP_QC_ASYNC1   = 3'h3;
   localparam logic [2:0] MSP_QC_UNDERRUN = 3'h5;
   localparam logic [2:0] MSP_QC_FULL     = 3'h6;
   localparam logic [2:0] MSP_QC_QUEUE_ALMOST_FULL    = 3'h7;

   typedef enum logic [3:0] {
      MSP_TX_ABORT    = 4'h0,
      MSP_TX_TOKEN    = 4'h1,
      MSP_TX_SYNC     = 4'h2,
      MSP_TX_ASYNC0   = 4'h3,
      MSP_TX_ASYNC1   = 4'h4,
      MSP_TX_CLAIM    = 4'h5,
      MSP_TX_BEACON   = 4'h6,
      MSP_TX_VOID     = 4'h7,
      MSP_TX_MAC_ABT  = 4'h8,
      MSP_TX_VOID_ABT = 4'h9
   } msp_tx_kind_t;

   typedef enum logic [2:0] {
      MSP_RX_NONE      = 3'h0,
      MSP_RX_SD_NDATA  = 3'h1,
      MSP_RX_STRIP     = 3'h2,
      MSP_RX_ABORT     = 3'h3,
      MSP_RX_FLUSH     = 3'h4
   } msp_rx_kind_t;

   typedef enum logic [1:0] {
      MSP_Q_NONE   = 2'h0,
      MSP_Q_SYNC   = 2'h1,
      MSP_Q_ASYNC0 = 2'h2,
      MSP_Q_ASYNC1 = 2'h3
   } msp_queue_t;

   typedef struct packed {
      logic         valid;
      logic         repeated;
      msp_tx_kind_t kind;
   } msp_tx_evt_t;

   typedef struct packed {
      msp_rx_kind_t kind;
      logic [4:0]   legacy;
      logic         online_special_mode;
   } msp_rx_evt_t;

   typedef struct packed {
      msp_queue_t unload;
      logic       underrun;
      logic       full;
      logic       queue_almost_full;
      logic       host_write_req;
   } msp_q_state_t;

   typedef struct packed {
      logic [3:0] tx_status_code;
      logic [5:0] rx_status_code;
      logic [2:0] queue_control_code;
   } msp_pins_t;
endpackage

// ---- verification/msp_encoder_assertions.sv ----
// Purpose: concurrent checks on the status pin codes
// Assumes: bound to msp_encoder, one clock domain
// Notes:   mode bits are not visible here
`timescale 1ns/100ps
module msp_encoder_assertions import msp_pkg::*; (
   // clock and reset
   input wire logic         clk,
   input wire logic         rst_n,
   // watched ports
   input wire msp_tx_evt_t  tx_evt,
   input wire msp_q_state_t q_state,
   input wire msp_pins_t    pins
);
   logic [3:0] xs;
   logic [5:0] rs;
   logic [2:0] qc;
   logic       tv;
   assign xs = pins.tx_status_code;
   assign rs = pins.rx_status_code;
   assign qc = pins.queue_control_code;
   assign tv = tx_evt.valid & ~tx_evt.repeated;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_tx_no_reserved: assert property (!(xs inside {4'h3, 4'h7, 4'h8, 4'hE, 4'hF}))
      else $error("reserved tx code");
   a_tx_one_shot: assert property (xs != MSP_XS_QUIET |-> $past(tv))
      else $error("tx code without event");
   a_tx_repeat_quiet: assert property (tx_evt.valid && tx_evt.repeated |=> xs == 4'h0)
      else $error("tx code for repeated frame");
   a_tx_token_code: assert property (tv && tx_evt.kind == MSP_TX_TOKEN |=> xs == 4'h2)
      else $error("token code wrong");
   a_rx_no_reserved: assert property (rs[5] |-> rs inside {6'h21, 6'h29, 6'h22, 6'h25, 6'h26})
      else $error("reserved rx code");
   a_qc_no_async2: assert property (qc != 3'h4)
      else $error("queue code 100 driven");
   a_qc_underrun: assert property (q_state.underrun |=> qc == MSP_QC_UNDERRUN)
      else $error("underrun code missing");
   a_qc_full_wins: assert property (q_state.full && !q_state.underrun |=> qc == 3'h6)
      else $error("full code missing");
   c_token: cover property (xs == MSP_XS_TOKEN);
   c_rx_abort: cover property (rs == MSP_RS_ABORT);
   c_queue_almost_full_run: cover property (qc == MSP_QC_QUEUE_ALMOST_FULL [*2]);
endmodule
bind msp_encoder msp_encoder_assertions u_chk (.clk(clk), .rst_n(rst_n), .tx_evt(tx_evt),
   .q_state(q_state), .pins(pins));

// ---- verification/msp_pin_observer.sv ----
// Purpose: far-side watcher standing for host and buffer logic
// Assumes: pins decoded on every rising clock edge
// Notes:   reserved codes are dropped and only flagged
`timescale 1ns/100ps
module msp_pin_observer import msp_pkg::*; (
   // clock and reset
   input  wire logic      clk,
   input  wire logic      rst_n,
   // watched pins
   input  wire msp_pins_t pins,
   // reserved code seen
   output logic           rsv_seen_q
);
   logic [5:0] rs;
   logic       rsv_d;
   assign rs = pins.rx_status_code;
   assign rsv_d = (pins.tx_status_code inside {4'h3, 4'h7, 4'h8, 4'hE, 4'hF})
      || (rs[5] && !(rs inside {6'h21, 6'h29, 6'h22, 6'h25, 6'h26}))
      || (pins.queue_control_code == 3'h4);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsv_seen_q <= 1'b0;
      end else if (rsv_d) begin
         rsv_seen_q <= 1'b1;
      end
   end
endmodule

// ---- verification/msp_encoder_tb.sv ----
// Purpose: self-checking bench for the status pin encoder
// Assumes: a set mask bit lets its status bit reach irq
// Notes:   each note is compared two edges after it is driven
`timescale 1ns/100ps
module msp_encoder_tb import msp_pkg::*; ;
   logic         clk = 1'b0;
   logic         rst_n, reg_wr, reg_rd, irq, rsv_seen;
   logic [7:0]   reg_addr;
   logic [31:0]  reg_wdata, reg_rdata, rnd, e;
   logic [2:0]   obs, obs_d;
   msp_tx_evt_t  tx_evt;
   msp_rx_evt_t  rx_evt;
   msp_q_state_t q_state;
   msp_pins_t    pins;
   logic [31:0]  exp_q[$];
   int           failures = 0;
   int           samples_checked = 0;
   logic [3:0]   xs_tab[10] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
   logic [5:0]   rs_tab[6] = '{6'h00, 6'h21, 6'h00, 6'h25, 6'h26, 6'h22};
   logic [5:0]   qs_tab[7] = '{6'h10, 6'h20, 6'h30, 6'h00, 6'h1C, 6'h27, 6'h12};
   logic [2:0]   qc_tab[7] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h5, 3'h6, 3'h1};
   always #2.5 clk = ~clk;
   msp_encoder dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_evt(tx_evt),
      .rx_evt(rx_evt), .q_state(q_state), .pins(pins), .irq(irq));
   msp_pin_observer far (.clk(clk), .rst_n(rst_n), .pins(pins), .rsv_seen_q(rsv_seen));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] seen(input logic [2:0] s);
      case (s)
         3'h1: return reg_rdata;
         3'h2: return {28'h0, pins.tx_status_code};
         3'h3: return {26'h0, pins.rx_status_code};
         3'h4: return {29'h0, pins.queue_control_code};
         default: return {31'h0, irq};
      endcase
   endfunction
   task automatic check(input logic [31:0] s, x);
      samples_checked++;
      if (s !== x) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, x);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic cyc(input logic w, r, input logic [7:0] a, input logic [31:0] d,
                      input msp_tx_evt_t t, input logic [2:0] s, input logic [31:0] x);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      tx_evt <= t;
      obs <= s;
      if (s != 3'h0) exp_q.push_back(x);
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cyc(1'b1, 1'b0, a, d, '0, 3'h0, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [2:0] s, input logic [31:0] x);
      cyc(1'b0, 1'b1, a, 32'h0, '0, s, x);
   endtask
   task automatic idle(input logic [2:0] s, input logic [31:0] x);
      cyc(1'b0, 1'b0, 8'h0, 32'h0, '0, s, x);
   endtask
   always @(posedge clk) begin
      obs_d <= obs;
      if (obs_d != 3'h0) check(seen(obs_d), exp_q.pop_front());
   end
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      wrap_up();
   end
   initial begin
      rst_n = 1'b0;
      {reg_wr, reg_rd, reg_addr, reg_wdata, tx_evt, rx_evt, q_state, obs} = '0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(MSP_OFS_MODE3, 3'h1, 32'h0);
      rd(MSP_OFS_MASK, 3'h1, 32'h0);
      rnd = lfsr(32'h9465AFE3);
      wr(MSP_OFS_MODE1, rnd);
      wr(8'h40, 32'hFFFFFFFF);
      rd(MSP_OFS_MODE1, 3'h1, {16'h0, rnd[15:0]});
      rd(8'h40, 3'h1, 32'h0);
      $display("register test done");
      for (int m = 0; m < 2; m++) begin
         wr(MSP_OFS_MODE3, 32'(m));
         for (int k = 0; k < 10; k++) begin
            e = (m == 0 && xs_tab[k][3]) ? 32'h0 : {28'h0, xs_tab[k]};
            cyc(1'b0, 1'b0, 8'h0, 32'h0, '{1'b1, 1'b0, msp_tx_kind_t'(k)}, 3'h2, e);
            cyc(1'b0, 1'b0, 8'h0, 32'h0, '{1'b1, 1'b1, msp_tx_kind_t'(k)}, 3'h2, 32'h0);
         end
      end
      $display("transmit test done");
      for (int m = 0; m < 2; m++) begin
         wr(MSP_OFS_MODE3, 32'(m * 2));
         for (int k = 0; k < 6; k++) begin
            rnd = lfsr(rnd);
            rx_evt <= '{msp_rx_kind_t'(k == 5 ? 2 : k), rnd[4:0], k == 5};
            e = (m == 1 && rs_tab[k] != 6'h0) ? {26'h0, rs_tab[k]} : {27'h0, rnd[4:0]};
            idle(3'h3, e);
         end
      end
      $display("receive test done");
      for (int k = 0; k < 7; k++) begin
         q_state <= qs_tab[k];
         idle(3'h4, {29'h0, qc_tab[k]});
      end
      wr(MSP_OFS_MODE3, 32'h4);
      q_state <= 6'h13;
      repeat (4) idle(3'h4, 32'h7);
      q_state <= 6'h17;
      idle(3'h4, 32'h6);
      q_state <= 6'h12;
      wr(MSP_OFS_MODE3, 32'h0);
      q_state <= 6'h13;
      idle(3'h4, 32'h7);
      repeat (2) idle(3'h4, 32'h1);
      rd(MSP_OFS_PINS, 3'h1, {19'h0, 4'h0, 1'b0, rnd[4:0], 3'h1});
      q_state <= 6'h00;
      $display("queue test done");
      rd(MSP_OFS_STATUS, 3'h0, 32'h0);
      wr(MSP_OFS_MASK, 32'h1F);
      cyc(1'b0, 1'b0, 8'h0, 32'h0, '{1'b1, 1'b0, MSP_TX_ABORT}, 3'h5, 32'h1);
      idle(3'h5, 32'h1);
      rd(MSP_OFS_STATUS, 3'h1, 32'h1);
      rd(MSP_OFS_STATUS, 3'h1, 32'h0);
      wr(MSP_OFS_MASK, 32'h0);
      cyc(1'b0, 1'b0, 8'h0, 32'h0, '{1'b1, 1'b0, MSP_TX_ABORT}, 3'h5, 32'h0);
      rd(MSP_OFS_STATUS, 3'h1, 32'h1);
      idle(3'h0, 32'h0);
      idle(3'h5, 32'h0);
      $display("interrupt test done");
      repeat (3) idle(3'h0, 32'h0);
      check({31'h0, rsv_seen}, 32'h0);
      wr(MSP_OFS_MODE3, 32'h7);
      rd(MSP_OFS_MODE3, 3'h1, 32'h7);
      idle(3'h0, 32'h0);
      rst_n <= 1'b0;
      idle(3'h0, 32'h0);
      rst_n <= 1'b1;
      idle(3'h0, 32'h0);
      rd(MSP_OFS_MODE3, 3'h1, 32'h0);
      repeat (2) idle(3'h0, 32'h0);
      $display("reset test done");
      wrap_up();
   end
endmodule
